/* hdl/rtc_map.svh */
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH
// direct i/o locations
`define SELECTOR_PORT 8'h70
`define WINDOW_PORT 8'h71
// indexed locations
`define IDX_CUR_SEC 7'h00
`define IDX_ALM_SEC 7'h01
`define IDX_CUR_MIN 7'h02
`define IDX_ALM_MIN 7'h03
`define IDX_CUR_HR 7'h04
`define IDX_ALM_HR 7'h05
`define IDX_WEEKDAY 7'h06
`define IDX_MONTH_DAY 7'h07
`define IDX_MONTH 7'h08
`define IDX_YEAR 7'h09
`define IDX_CTL_FIRST 7'h0a
`define IDX_CTL_SECOND 7'h0b
`define IDX_STAT_THIRD 7'h0c
`define IDX_STAT_FOURTH 7'h0d
`define IDX_STORAGE_LO 7'h0e
`define STORAGE_BYTES 114
// field positions in clock_control_second
`define CTL_SET_BIT 7
`define CTL_ALARM_IRQ_ENABLE_BIT 5
`define CTL_BINARY_SELECT_BIT 2
// field positions in clock_status_third
`define STAT_IRQ_BIT 7
`define STAT_ALARM_FLAG_BIT 5
// values
`define SELECTOR_RESET 7'h00
`define CTL_SECOND_RESET 8'h04
`define WILDCARD_MASK 8'hc0
`define SEC_MAX_BIN 8'h3b
`define SEC_MAX_BCD 8'h59
`define HR_MAX_BIN 8'h17
`define HR_MAX_BCD 8'h23
`define STATUS_FOURTH_VALUE 8'h80
// timing
`define TICK_PERIOD_NS 1000000000
`define CLOCK_PERIOD_NS 50
`endif

/* hdl/rtc_pkg.sv */
package rtc_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } io_req_type;
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hr;
  } time_type;
  typedef enum logic [1:0] {
    TICK_IDLE = 2'b01,
    TICK_STEP = 2'b10
  } tick_state_type;
endpackage

/* hdl/rtc_step.sv */
`timescale 1ns/1ps
`include "rtc_map.svh"
module rtc_step (
  input wire logic [7:0] value_i,
  input wire logic [7:0] max_bin_i,
  input wire logic [7:0] max_bcd_i,
  input wire logic binary_i,
  output logic [7:0] next_o,
  output logic carry_o
);
  logic [7:0] max_v;
  logic [7:0] bcd_inc;
  always_comb begin
    max_v = binary_i ? max_bin_i : max_bcd_i;
    if (value_i[3:0] >= 4'h9) begin
      bcd_inc = {value_i[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = value_i + 8'h01;
    end
    carry_o = 1'b0;
    // in range wraps at max, out of range counts through ffh to zero
    if (value_i == max_v) begin
      next_o = 8'h00;
      carry_o = 1'b1;
    end else if (value_i > max_v) begin
      next_o = value_i + 8'h01;
    end else begin
      next_o = binary_i ? value_i + 8'h01 : bcd_inc;
    end
  end
endmodule

/* hdl/rtc_core.sv */
`timescale 1ns/1ps
`include "rtc_map.svh"
// Behaviour
// - decode only ports 70h and 71h
// - selector bits 6-0, reset zero
// - selector bit 7 reserved, no nmi gate
// - data port reaches currently selected location
// - indices 00h-0dh map clock registers
// - indices 0eh-7fh reach 114 storage bytes
// - seconds writable, readable, ticked each second
// - minutes writable, readable, advanced on seconds carry
// - out-of-range values count through ffh
// - binary or bcd by control bit
// - set bit suspends time updates
// - alarm second c0h-ffh is wildcard
// - alarm needs hours, minutes, seconds match
// - alarm compared once per second
// - match sets flag; irq needs enable
// - alarm minute c0h-ffh is wildcard
// - alarm hour c0h-ffh is wildcard
module rtc_core #(
  parameter int TICK_CYCLES = `TICK_PERIOD_NS / `CLOCK_PERIOD_NS
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input rtc_pkg::io_req_type io_req_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output logic alarm_irq_o,
  output rtc_pkg::time_type time_o
);
  import rtc_pkg::*;

  // ============================================================
  // state
  typedef struct packed {
    tick_state_type st;
    logic [31:0] cnt;
    logic [6:0] selector;
    time_type cur;
    time_type alm;
    logic [7:0] weekday;
    logic [7:0] month_day;
    logic [7:0] month;
    logic [7:0] year;
    logic [7:0] ctl_first;
    logic [7:0] ctl_second;
    logic alarm_flag;
    logic [7:0] rdata;
    logic rvalid;
  } state_type;

  state_type state_r;
  state_type state_nxt;
  logic [7:0] storage_r [`STORAGE_BYTES];
  logic [7:0] sec_next;
  logic [7:0] min_next;
  logic [7:0] hr_next;
  logic sec_carry;
  logic min_carry;
  logic hr_carry;
  logic binary;
  logic sec_hit;
  logic min_hit;
  logic hr_hit;
  logic alarm_hit;
  logic sel_port;
  logic win_port;
  logic storage_hit;
  logic [6:0] storage_idx;
  logic [7:0] status_third;

  // ============================================================
  // counting
  assign binary = state_r.ctl_second[`CTL_BINARY_SELECT_BIT];

  rtc_step sec_step (
    .value_i(state_r.cur.sec),
    .max_bin_i(`SEC_MAX_BIN),
    .max_bcd_i(`SEC_MAX_BCD),
    .binary_i(binary),
    .next_o(sec_next),
    .carry_o(sec_carry)
  );
  rtc_step min_step (
    .value_i(state_r.cur.min),
    .max_bin_i(`SEC_MAX_BIN),
    .max_bcd_i(`SEC_MAX_BCD),
    .binary_i(binary),
    .next_o(min_next),
    .carry_o(min_carry)
  );
  rtc_step hr_step (
    .value_i(state_r.cur.hr),
    .max_bin_i(`HR_MAX_BIN),
    .max_bcd_i(`HR_MAX_BCD),
    .binary_i(binary),
    .next_o(hr_next),
    .carry_o(hr_carry)
  );

  // ============================================================
  // alarm compare
  always_comb begin
    sec_hit = ((state_r.alm.sec & `WILDCARD_MASK) == `WILDCARD_MASK)
      || (state_r.alm.sec == state_r.cur.sec);
    min_hit = ((state_r.alm.min & `WILDCARD_MASK) == `WILDCARD_MASK)
      || (state_r.alm.min == state_r.cur.min);
    hr_hit = ((state_r.alm.hr & `WILDCARD_MASK) == `WILDCARD_MASK)
      || (state_r.alm.hr == state_r.cur.hr);
    alarm_hit = sec_hit && min_hit && hr_hit;
  end

  // ============================================================
  // i/o decode
  always_comb begin
    sel_port = (io_req_i.addr == `SELECTOR_PORT);
    win_port = (io_req_i.addr == `WINDOW_PORT);
    storage_hit = (state_r.selector >= `IDX_STORAGE_LO);
    storage_idx = state_r.selector - `IDX_STORAGE_LO;
    status_third = 8'h00;
    status_third[`STAT_ALARM_FLAG_BIT] = state_r.alarm_flag;
    status_third[`STAT_IRQ_BIT] = state_r.alarm_flag && state_r.ctl_second[`CTL_ALARM_IRQ_ENABLE_BIT];
  end

  // ============================================================
  // next state
  always_comb begin
    state_nxt = state_r;
    state_nxt.rvalid = 1'b0;
    case (state_r.st)
      TICK_IDLE: begin
        if (state_r.cnt == 32'(TICK_CYCLES - 1)) begin
          state_nxt.cnt = 32'h0;
          state_nxt.st = TICK_STEP;
        end else begin
          state_nxt.cnt = state_r.cnt + 32'h1;
        end
      end
      TICK_STEP: begin
        state_nxt.st = TICK_IDLE;
        state_nxt.cnt = state_r.cnt + 32'h1;
        if (!state_r.ctl_second[`CTL_SET_BIT]) begin
          state_nxt.cur.sec = sec_next;
          if (sec_carry) begin
            state_nxt.cur.min = min_next;
            if (min_carry) begin
              state_nxt.cur.hr = hr_next;
            end
          end
          if (alarm_hit) begin
            state_nxt.alarm_flag = 1'b1;
          end
        end
      end
      default: begin
        state_nxt.st = TICK_IDLE;
        state_nxt.cnt = 32'h0;
      end
    endcase
    if (io_req_i.wr && sel_port) begin
      state_nxt.selector = io_req_i.wdata[6:0];
    end
    if (io_req_i.wr && win_port) begin
      case (state_r.selector)
        `IDX_CUR_SEC: state_nxt.cur.sec = io_req_i.wdata;
        `IDX_ALM_SEC: state_nxt.alm.sec = io_req_i.wdata;
        `IDX_CUR_MIN: state_nxt.cur.min = io_req_i.wdata;
        `IDX_ALM_MIN: state_nxt.alm.min = io_req_i.wdata;
        `IDX_CUR_HR: state_nxt.cur.hr = io_req_i.wdata;
        `IDX_ALM_HR: state_nxt.alm.hr = io_req_i.wdata;
        `IDX_WEEKDAY: state_nxt.weekday = io_req_i.wdata;
        `IDX_MONTH_DAY: state_nxt.month_day = io_req_i.wdata;
        `IDX_MONTH: state_nxt.month = io_req_i.wdata;
        `IDX_YEAR: state_nxt.year = io_req_i.wdata;
        `IDX_CTL_FIRST: state_nxt.ctl_first = io_req_i.wdata;
        `IDX_CTL_SECOND: state_nxt.ctl_second = io_req_i.wdata;
        default: begin
        end
      endcase
    end
    if (io_req_i.rd && (sel_port || win_port)) begin
      state_nxt.rvalid = 1'b1;
      state_nxt.rdata = 8'h00;
      if (win_port) begin
        case (state_r.selector)
          `IDX_CUR_SEC: state_nxt.rdata = state_r.cur.sec;
          `IDX_ALM_SEC: state_nxt.rdata = state_r.alm.sec;
          `IDX_CUR_MIN: state_nxt.rdata = state_r.cur.min;
          `IDX_ALM_MIN: state_nxt.rdata = state_r.alm.min;
          `IDX_CUR_HR: state_nxt.rdata = state_r.cur.hr;
          `IDX_ALM_HR: state_nxt.rdata = state_r.alm.hr;
          `IDX_WEEKDAY: state_nxt.rdata = state_r.weekday;
          `IDX_MONTH_DAY: state_nxt.rdata = state_r.month_day;
          `IDX_MONTH: state_nxt.rdata = state_r.month;
          `IDX_YEAR: state_nxt.rdata = state_r.year;
          `IDX_CTL_FIRST: state_nxt.rdata = state_r.ctl_first;
          `IDX_CTL_SECOND: state_nxt.rdata = state_r.ctl_second;
          `IDX_STAT_THIRD: begin
            state_nxt.rdata = status_third;
            // read clears the flag unless an alarm lands now
            if (!(state_r.st == TICK_STEP && !state_r.ctl_second[`CTL_SET_BIT] && alarm_hit)) begin
              state_nxt.alarm_flag = 1'b0;
            end
          end
          `IDX_STAT_FOURTH: state_nxt.rdata = `STATUS_FOURTH_VALUE;
          default: state_nxt.rdata = storage_r[storage_idx];
        endcase
      end
    end
  end

  // ============================================================
  // registers
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= '0;
      state_r.st <= TICK_IDLE;
      state_r.selector <= `SELECTOR_RESET;
      state_r.ctl_second <= `CTL_SECOND_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // storage has no reset, as battery-backed ram
  always_ff @(posedge mclk_i) begin
    if (io_req_i.wr && win_port && storage_hit) begin
      storage_r[storage_idx] <= io_req_i.wdata;
    end
  end

  assign rdata_o = state_r.rdata;
  assign rvalid_o = state_r.rvalid;
  assign alarm_irq_o = state_r.alarm_flag && state_r.ctl_second[`CTL_ALARM_IRQ_ENABLE_BIT];
  assign time_o = state_r.cur;

  // ============================================================
  // checks
  chk_selector_load: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    io_req_i.wr && sel_port |=> state_r.selector == $past(io_req_i.wdata[6:0]))
    else $error("selector did not load");
  chk_set_holds: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    state_r.st == TICK_STEP && state_r.ctl_second[`CTL_SET_BIT] && !io_req_i.wr
      |=> $stable(state_r.cur))
    else $error("time moved while set");
  chk_sec_tick: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    state_r.st == TICK_STEP && !state_r.ctl_second[`CTL_SET_BIT] && !io_req_i.wr
      |=> state_r.cur.sec == $past(sec_next))
    else $error("seconds not ticked");
  chk_min_carry: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    state_r.st == TICK_STEP && !state_r.ctl_second[`CTL_SET_BIT] && !sec_carry && !io_req_i.wr
      |=> $stable(state_r.cur.min))
    else $error("minutes moved without carry");
  chk_alarm_set: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    state_r.st == TICK_STEP && !state_r.ctl_second[`CTL_SET_BIT] && alarm_hit |=> state_r.alarm_flag)
    else $error("alarm flag not set");
  chk_alarm_quiet: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    !state_r.alarm_flag && state_r.st == TICK_IDLE |=> !state_r.alarm_flag)
    else $error("alarm flag set off tick");
  chk_irq_gate: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    !state_r.ctl_second[`CTL_ALARM_IRQ_ENABLE_BIT] |-> !alarm_irq_o)
    else $error("irq while disabled");
  chk_wild_sec: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    state_r.alm.sec >= 8'hc0 |-> sec_hit)
    else $error("seconds wildcard missed");
  chk_read_answer: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    io_req_i.rd && win_port && state_r.selector == `IDX_CUR_MIN
      |=> rvalid_o && rdata_o == $past(state_r.cur.min))
    else $error("window read wrong");
  chk_tick_period: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    state_r.st == TICK_STEP |=> state_r.st == TICK_IDLE)
    else $error("tick not one cycle");
  chk_other_port: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    io_req_i.wr && !sel_port && !win_port
      |=> state_r.selector == $past(state_r.selector) && state_r.alm == $past(state_r.alm))
    else $error("write to other port landed");
  chk_other_read: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    io_req_i.rd && !sel_port && !win_port
      |=> !rvalid_o)
    else $error("read of other port answered");
  chk_bit7_dropped: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    io_req_i.wr && sel_port && io_req_i.wdata[7]
      |=> state_r.selector == $past(io_req_i.wdata[6:0]) && state_r.ctl_second == $past(state_r.ctl_second))
    else $error("selector bit 7 had an effect");
  chk_read_selector: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    io_req_i.rd && sel_port
      |=> rvalid_o && rdata_o == 8'h00)
    else $error("selector read not zero");
  chk_alarm_sec_load: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    io_req_i.wr && win_port && state_r.selector == `IDX_ALM_SEC
      |=> state_r.alm.sec == $past(io_req_i.wdata))
    else $error("alarm second not loaded");
  chk_alarm_min_load: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    io_req_i.wr && win_port && state_r.selector == `IDX_ALM_MIN
      |=> state_r.alm.min == $past(io_req_i.wdata))
    else $error("alarm minute not loaded");
  chk_alarm_hr_load: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    io_req_i.wr && win_port && state_r.selector == `IDX_ALM_HR
      |=> state_r.alm.hr == $past(io_req_i.wdata))
    else $error("alarm hour not loaded");
  chk_min_load: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    io_req_i.wr && win_port && state_r.selector == `IDX_CUR_MIN
      |=> state_r.cur.min == $past(io_req_i.wdata))
    else $error("minute not loaded");
  chk_read_status: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    io_req_i.rd && win_port && state_r.selector == `IDX_STAT_THIRD
      |=> rdata_o[`STAT_ALARM_FLAG_BIT] == $past(state_r.alarm_flag))
    else $error("status flag read wrong");
  chk_flag_clear: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    io_req_i.rd && win_port && state_r.selector == `IDX_STAT_THIRD && !(state_r.st == TICK_STEP && alarm_hit)
      |=> !state_r.alarm_flag)
    else $error("flag not cleared by read");
  chk_wild_min: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    state_r.alm.min >= 8'hc0
      |-> min_hit)
    else $error("minutes wildcard missed");
  chk_wild_hr: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    state_r.alm.hr >= 8'hc0
      |-> hr_hit)
    else $error("hours wildcard missed");
  chk_hr_gate: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    !state_r.alarm_flag && !hr_hit
      |=> !state_r.alarm_flag)
    else $error("alarm without hour match");
  chk_fourth_const: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    io_req_i.rd && win_port && state_r.selector == `IDX_STAT_FOURTH
      |=> rdata_o == `STATUS_FOURTH_VALUE)
    else $error("status fourth read wrong");
  chk_storage_read: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    io_req_i.rd && win_port && storage_hit
      |=> rdata_o == $past(storage_r[storage_idx]))
    else $error("storage read wrong");
  chk_sec_wrap: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    state_r.st == TICK_STEP && !state_r.ctl_second[`CTL_SET_BIT] && !io_req_i.wr && state_r.cur.sec == 8'hff
      |=> state_r.cur.sec == 8'h00)
    else $error("seconds did not wrap");
  chk_bcd_step: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    state_r.st == TICK_STEP && !state_r.ctl_second[`CTL_SET_BIT] && !io_req_i.wr && !binary && state_r.cur.sec == 8'h09
      |=> state_r.cur.sec == 8'h10)
    else $error("bcd seconds step wrong");
  chk_min_advance: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    state_r.st == TICK_STEP && !state_r.ctl_second[`CTL_SET_BIT] && !io_req_i.wr && sec_carry
      |=> state_r.cur.min == $past(min_next))
    else $error("minutes not advanced on carry");
  chk_irq_follows: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    state_r.alarm_flag && state_r.ctl_second[`CTL_ALARM_IRQ_ENABLE_BIT]
      |-> alarm_irq_o)
    else $error("irq missing while enabled");
endmodule

/* tb/rtc_host.sv */
`timescale 1ns/1ps
// ==========
// host i/o model
module rtc_host (
  input wire logic mclk_i,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i,
  output rtc_pkg::io_req_type io_req_o
);
  import rtc_pkg::*;
  initial begin
    io_req_o = '{1'b0, 1'b0, 8'h8e, 8'h5a};
  end
  // released bus shows inverted address and data
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    io_req_o = '{1'b1, 1'b0, a, d};
    @(negedge mclk_i);
    io_req_o = '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic get(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(negedge mclk_i);
    io_req_o = '{1'b0, 1'b1, a, 8'h3c};
    @(negedge mclk_i);
    io_req_o = '{1'b0, 1'b0, ~a, 8'hc3};
    d = rdata_i;
    ok = rvalid_i;
  endtask
  // selector first, then the window
  task automatic iwr(input logic [6:0] i, input logic [7:0] d);
    put(8'h70, {1'b0, i});
    put(8'h71, d);
  endtask
  task automatic ird(input logic [6:0] i, output logic [7:0] d);
    logic ok;
    put(8'h70, {1'b0, i});
    get(8'h71, d, ok);
  endtask
endmodule

/* tb/test_rtc_core.sv */
`timescale 1ns/1ps
// ==========
// bench
module test_rtc_core;
  import rtc_pkg::*;
  localparam int TICK = 10;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  io_req_type io_req;
  logic [7:0] rdata, v, d, es, em, eh;
  logic rvalid, irq, ok;
  logic [6:0] idx;
  time_type tnow;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [7:0] tc [5][4] = '{'{8'h3b, 8'h3b, 8'h05, 8'h04}, '{8'hff, 8'h10, 8'h01, 8'h04},
    '{8'h59, 8'h59, 8'h05, 8'h00}, '{8'h09, 8'h12, 8'h05, 8'h00}, '{8'h1e, 8'h3b, 8'h16, 8'h04}};
  logic [7:0] ac [6][4] = '{'{8'hc0, 8'hff, 8'he7, 8'h01}, '{8'h05, 8'hff, 8'hc0, 8'h01},
    '{8'h06, 8'hc0, 8'hc0, 8'h00}, '{8'h05, 8'h3a, 8'hc0, 8'h00}, '{8'h05, 8'h10, 8'h05, 8'h01},
    '{8'h05, 8'hc0, 8'h04, 8'h00}};
  rtc_core #(.TICK_CYCLES(TICK)) DUT (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .io_req_i(io_req),
    .rdata_o(rdata), .rvalid_o(rvalid), .alarm_irq_o(irq), .time_o(tnow));
  rtc_host host (.mclk_i(mclk_i), .rdata_i(rdata), .rvalid_i(rvalid), .io_req_o(io_req));
  initial begin
    forever #25 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_reg(input logic [6:0] i, input logic [7:0] exp, input string what);
    logic [7:0] r;
    host.ird(i, r);
    check(r, exp, what);
  endtask
  task automatic wait_sec(input logic [7:0] s);
    for (int i = 0; i < 3 * TICK && tnow.sec === s; i++) @(negedge mclk_i);
  endtask
  function automatic logic [7:0] limit(input logic bin, input logic hour);
    if (hour) return bin ? 8'h17 : 8'h23;
    return bin ? 8'h3b : 8'h59;
  endfunction
  function automatic logic [7:0] step(input logic [7:0] x, input logic bin, input logic hour);
    if (x == limit(bin, hour)) return 8'h00;
    if (bin || x > limit(bin, hour) || x[3:0] != 4'h9) return x + 8'h01;
    return {x[7:4] + 4'h1, 4'h0};
  endfunction
  task automatic load(input logic [7:0] s, input logic [7:0] m, input logic [7:0] h, input logic [7:0] c);
    host.iwr(7'h0b, c | 8'h80);
    host.iwr(7'h00, s);
    host.iwr(7'h02, m);
    host.iwr(7'h04, h);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    void'($urandom(97941));
    repeat (2) @(posedge mclk_i);
    @(negedge mclk_i) reset_n_i = 1'b1;
    host.get(8'h70, v, ok);
    check(v, 8'h00, "selector read");
    chk_reg(7'h0b, 8'h04, "control reset");
    for (int i = 6; i < 11; i++) begin
      d = 8'($urandom);
      host.iwr(7'(i), d);
      chk_reg(7'(i), d, "clock register");
    end
    host.iwr(7'h0d, 8'h00);
    chk_reg(7'h0d, 8'h80, "status fourth");
    $display("test reset done");
    for (int i = 0; i < 24; i++) begin
      idx = 7'($urandom_range(14, 127));
      d = 8'($urandom);
      host.put(8'h70, {1'($urandom), idx});
      host.put(8'h71, d);
      host.put(8'h72, ~d);
      host.get(8'h71, v, ok);
      check(v, d, "storage");
      check({7'h00, ok}, 8'h01, "read answer");
      host.get(8'h73, v, ok);
      check({7'h00, ok}, 8'h00, "unmapped read");
    end
    $display("test storage done");
    tc[4][0] = 8'($urandom_range(0, 58));
    for (int i = 0; i < 5; i++) begin
      load(tc[i][0], tc[i][1], tc[i][2], tc[i][3]);
      repeat (3 * TICK) @(negedge mclk_i);
      check(tnow.sec, tc[i][0], "set holds");
      host.iwr(7'h0b, tc[i][3]);
      wait_sec(tc[i][0]);
      es = step(tc[i][0], tc[i][3][2], 1'b0);
      em = (tc[i][0] == limit(tc[i][3][2], 1'b0)) ? step(tc[i][1], tc[i][3][2], 1'b0) : tc[i][1];
      eh = (tc[i][0] == limit(tc[i][3][2], 1'b0) && tc[i][1] == limit(tc[i][3][2], 1'b0))
        ? step(tc[i][2], tc[i][3][2], 1'b1) : tc[i][2];
      check(tnow.sec, es, "second tick");
      check(tnow.min, em, "minute carry");
      check(tnow.hr, eh, "hour carry");
      chk_reg(7'h02, em, "minute read");
    end
    $display("test time done");
    ac[0][0] = 8'($urandom_range(192, 255));
    for (int i = 0; i < 7; i++) begin
      load(8'h05, 8'h10, 8'h05, (i < 6) ? 8'h24 : 8'h04);
      host.iwr(7'h01, ac[i % 6][0]);
      host.iwr(7'h03, ac[i % 6][1]);
      host.iwr(7'h05, ac[i % 6][2]);
      host.ird(7'h0c, v);
      host.iwr(7'h0b, (i < 6) ? 8'h24 : 8'h04);
      wait_sec(8'h05);
      @(negedge mclk_i);
      check({7'h00, irq}, (i < 6) ? ac[i][3] : 8'h00, "alarm irq");
      host.ird(7'h0c, v);
      check({7'h00, v[5]}, ac[i % 6][3], "alarm flag");
      check({7'h00, v[7]}, (i < 6) ? ac[i][3] : 8'h00, "irq status");
      check({7'h00, irq}, 8'h00, "irq after read");
    end
    $display("test alarm done");
    conclude();
  end
endmodule
